// ### shared/fddc_defs.vh
`ifndef FDDC_DEFS_VH
`define FDDC_DEFS_VH
// ****************************************
// Register indices and byte addresses
// ****************************************
`define FDDC_IDX_FIFO_DIAG     8'h04
`define FDDC_IDX_MAC_CTRL      8'h06
`define FDDC_IDX_INT_STATUS    8'h08
`define FDDC_IDX_INT_MASK      8'h09
`define FDDC_ADDR_LSB          2
// ****************************************
// Diagnostic register fields
// ****************************************
`define FDDC_TX_EN_BIT         0
`define FDDC_TX_MODE_BIT       1
`define FDDC_TX_RES_BIT        2
`define FDDC_TX_DONE_BIT       3
`define FDDC_RX_EN_BIT         4
`define FDDC_RX_MODE_BIT       5
`define FDDC_RX_RES_BIT        6
`define FDDC_RX_DONE_BIT       7
`define FDDC_PME_BLOCK_BIT     8
`define FDDC_RETAIN_BIT        9
`define FDDC_RX_FULL_BIT       11
`define FDDC_RECEIVING_BIT     15
`define FDDC_DIAG_WMASK        16'h0333
// ****************************************
// MAC control fields
// ****************************************
`define FDDC_DEFER_EN_BIT      0
`define FDDC_DEFER_CODE_LSB    1
`define FDDC_DEFER_CODE_MSB    4
`define FDDC_MAC_WMASK         16'h001F
// ****************************************
// Interrupt bits
// ****************************************
`define FDDC_INT_TX_DONE       0
`define FDDC_INT_RX_DONE       1
`define FDDC_INT_OVERRUN       2
`define FDDC_INT_WIDTH         3
// ****************************************
// Reset values and timing
// ****************************************
`define FDDC_REG_RESET         16'h0000
`define FDDC_STD_IFS_BITS      10'h060
`define FDDC_DEFER_STEP_BITS   9'h010
`define FDDC_BIST_WORDS        10'h200
`define FDDC_BIST_LAST         10'h1FF
`define FDDC_HTRANS_NONSEQ     2'h2
`endif

// ### src/fddc_top.v
// Functional notes
// - Tx self-test enable bit 0 and mode bit 1, both read/write.
// - Tx self-test result in bit 2, done flag in bit 3, read-only.
// - Rx self-test enable bit 4 and mode bit 5, both read/write.
// - Rx self-test result in bit 6, done flag in bit 7, read-only.
// - Power-event block bit 8 stops power events reaching the bus; resets 0.
// - Retain bit 9 clear drops overrun packets; set keeps visible ones.
// - Rx full flag bit 11 follows the receive FIFO full level.
// - Overrun only when data arrives while FIFO full, not full alone.
// - Receiving bit 15 high while a packet enters the receive FIFO.
// - MAC control register clears to zero on every reset.
// - Extended deference enable lengthens post-transmit deferral.
// - Enable clear gives the fixed standard deferral of 96 bit times.
// - Defer code 0,1,2 add 0,16,32; codes 3-9 add 64-256 by 32.
// - Defer codes A-F add 288-448 bit times in steps of 32.
// - Enable clear ignores the defer code; no extra deference.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "fddc_defs.vh"

module fddc_top (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg         tx_selftest_run,
  output reg         tx_selftest_mode,
  output reg  [9:0]  tx_selftest_addr,
  input  wire        tx_selftest_miscompare,
  output reg         rx_selftest_run,
  output reg         rx_selftest_mode,
  output reg  [9:0]  rx_selftest_addr,
  input  wire        rx_selftest_miscompare,
  input  wire        power_event_req,
  output reg         power_event_out,
  input  wire        rx_fifo_full,
  input  wire        rx_data_arrive,
  input  wire        rx_packet_active,
  output reg         rx_overrun,
  output reg         drop_overrun_packet,
  output reg         extended_deference_enable,
  output reg  [8:0]  extra_defer_bits,
  output reg  [9:0]  defer_total_bits,
  output reg         irq
);

  // ****************************************
  // State codes and helpers
  // ****************************************
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RUN  = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  function [8:0] defer_bits;
    input [3:0] code;
    begin
      if (code < 4'h3) begin
        defer_bits = {5'h00, code} * `FDDC_DEFER_STEP_BITS;
      end else begin
        defer_bits = ({5'h00, code} - 9'h001) * (`FDDC_DEFER_STEP_BITS << 1);
      end
    end
  endfunction

  function [15:0] w1_merge;
    input [15:0] old_val;
    input [15:0] wdata;
    input [15:0] wmask;
    begin
      w1_merge = (old_val & ~wmask) | (wdata & wmask);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg  [15:0] diag_ctrl_q;
  reg  [15:0] mac_parameter_control_q;
  reg  [2:0]  int_status_q;
  reg  [2:0]  int_mask_q;
  reg         wr_pend_q;
  reg  [7:0]  wr_idx_q;
  reg  [2:0]  tx_state_q;
  reg  [2:0]  rx_state_q;
  reg  [9:0]  tx_cnt_q;
  reg  [9:0]  rx_cnt_q;
  reg         tx_fail_q;
  reg         rx_fail_q;
  reg         tx_en_prev_q;
  reg         rx_en_prev_q;
  reg  [15:0] fifo_diagnostic_status;
  reg  [31:0] rdata_d;
  reg  [2:0]  int_events;
  reg  [2:0]  int_status_d;

  wire        addr_phase = hsel & hready & (htrans == `FDDC_HTRANS_NONSEQ);
  wire [7:0]  addr_idx   = haddr[`FDDC_ADDR_LSB+7:`FDDC_ADDR_LSB];
  wire        wr_diag    = wr_pend_q & (wr_idx_q == `FDDC_IDX_FIFO_DIAG);
  wire        wr_mac     = wr_pend_q & (wr_idx_q == `FDDC_IDX_MAC_CTRL);
  wire        wr_stat    = wr_pend_q & (wr_idx_q == `FDDC_IDX_INT_STATUS);
  wire        wr_mask    = wr_pend_q & (wr_idx_q == `FDDC_IDX_INT_MASK);
  wire        tx_en      = diag_ctrl_q[`FDDC_TX_EN_BIT];
  wire        rx_en      = diag_ctrl_q[`FDDC_RX_EN_BIT];
  wire        tx_start   = tx_en & ~tx_en_prev_q;
  wire        rx_start   = rx_en & ~rx_en_prev_q;
  wire        defer_en   = mac_parameter_control_q[`FDDC_DEFER_EN_BIT];
  wire [3:0]  defer_code = mac_parameter_control_q[`FDDC_DEFER_CODE_MSB:
                                                   `FDDC_DEFER_CODE_LSB];
  wire        overrun_now = rx_fifo_full & rx_data_arrive;
  wire        tx_done_vis = (tx_state_q == ST_DONE) & ~tx_start;
  wire        rx_done_vis = (rx_state_q == ST_DONE) & ~rx_start;

  // ****************************************
  // Read view of the diagnostic register
  // ****************************************
  always @* begin
    fifo_diagnostic_status = diag_ctrl_q & `FDDC_DIAG_WMASK;
    fifo_diagnostic_status[`FDDC_TX_RES_BIT]  = tx_done_vis
                                                & tx_fail_q;
    fifo_diagnostic_status[`FDDC_TX_DONE_BIT] = tx_done_vis;
    fifo_diagnostic_status[`FDDC_RX_RES_BIT]  = rx_done_vis
                                                & rx_fail_q;
    fifo_diagnostic_status[`FDDC_RX_DONE_BIT] = rx_done_vis;
    fifo_diagnostic_status[`FDDC_RX_FULL_BIT] = rx_fifo_full;
    fifo_diagnostic_status[`FDDC_RECEIVING_BIT] = rx_packet_active;
  end

  always @* begin
    rdata_d = 32'h00000000;
    case (addr_idx)
      `FDDC_IDX_FIFO_DIAG:  rdata_d = {16'h0000, fifo_diagnostic_status};
      `FDDC_IDX_MAC_CTRL:   rdata_d = {16'h0000, mac_parameter_control_q};
      `FDDC_IDX_INT_STATUS: rdata_d = {29'h00000000, int_status_q};
      `FDDC_IDX_INT_MASK:   rdata_d = {29'h00000000, int_mask_q};
      default:              rdata_d = 32'h00000000;
    endcase
  end

  // ****************************************
  // Bus slave
  // ****************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_idx_q <= addr_idx;
        hrdata   <= hwrite ? 32'h00000000 : rdata_d;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      diag_ctrl_q             <= `FDDC_REG_RESET;
      mac_parameter_control_q <= `FDDC_REG_RESET;
      int_mask_q              <= 3'h0;
    end else begin
      if (wr_diag) begin
        diag_ctrl_q <= w1_merge(diag_ctrl_q, hwdata[15:0],
                                `FDDC_DIAG_WMASK);
      end
      if (wr_mac) begin
        mac_parameter_control_q <= hwdata[15:0] & `FDDC_MAC_WMASK;
      end
      if (wr_mask) begin
        int_mask_q <= hwdata[2:0];
      end
    end
  end

  // ****************************************
  // Transmit FIFO self-test engine
  // ****************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_q   <= ST_IDLE;
      tx_cnt_q     <= 10'h000;
      tx_fail_q    <= 1'b0;
      tx_en_prev_q <= 1'b0;
    end else begin
      tx_en_prev_q <= tx_en;
      if (tx_start) begin
        tx_state_q <= ST_RUN;
        tx_cnt_q   <= 10'h000;
        tx_fail_q  <= 1'b0;
      end else begin
        case (tx_state_q)
          ST_IDLE: tx_state_q <= ST_IDLE;
          ST_RUN: begin
            tx_fail_q <= tx_fail_q | tx_selftest_miscompare;
            if (!tx_en) begin
              tx_state_q <= ST_IDLE;
            end else if (tx_cnt_q == `FDDC_BIST_LAST) begin
              tx_state_q <= ST_DONE;
            end else begin
              tx_cnt_q <= tx_cnt_q + 10'h001;
            end
          end
          ST_DONE: tx_state_q <= ST_DONE;
          default: tx_state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Receive FIFO self-test engine
  // ****************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_q   <= ST_IDLE;
      rx_cnt_q     <= 10'h000;
      rx_fail_q    <= 1'b0;
      rx_en_prev_q <= 1'b0;
    end else begin
      rx_en_prev_q <= rx_en;
      if (rx_start) begin
        rx_state_q <= ST_RUN;
        rx_cnt_q   <= 10'h000;
        rx_fail_q  <= 1'b0;
      end else begin
        case (rx_state_q)
          ST_IDLE: rx_state_q <= ST_IDLE;
          ST_RUN: begin
            rx_fail_q <= rx_fail_q | rx_selftest_miscompare;
            if (!rx_en) begin
              rx_state_q <= ST_IDLE;
            end else if (rx_cnt_q == `FDDC_BIST_LAST) begin
              rx_state_q <= ST_DONE;
            end else begin
              rx_cnt_q <= rx_cnt_q + 10'h001;
            end
          end
          ST_DONE: rx_state_q <= ST_DONE;
          default: rx_state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Interrupt status, set wins over clear
  // ****************************************
  always @* begin
    int_events = 3'h0;
    int_events[`FDDC_INT_TX_DONE] = (tx_state_q == ST_RUN) & tx_en
                                    & (tx_cnt_q == `FDDC_BIST_LAST) & ~tx_start;
    int_events[`FDDC_INT_RX_DONE] = (rx_state_q == ST_RUN) & rx_en
                                    & (rx_cnt_q == `FDDC_BIST_LAST) & ~rx_start;
    int_events[`FDDC_INT_OVERRUN] = overrun_now;
    int_status_d = int_status_q;
    if (wr_stat) begin
      int_status_d = int_status_q & ~hwdata[2:0];
    end
    int_status_d = int_status_d | int_events;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_status_q <= 3'h0;
      irq          <= 1'b0;
    end else begin
      int_status_q <= int_status_d;
      irq          <= |(int_status_d & int_mask_q);
    end
  end

  // ****************************************
  // Datapath outputs
  // ****************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_selftest_run           <= 1'b0;
      tx_selftest_mode          <= 1'b0;
      tx_selftest_addr          <= 10'h000;
      rx_selftest_run           <= 1'b0;
      rx_selftest_mode          <= 1'b0;
      rx_selftest_addr          <= 10'h000;
      power_event_out           <= 1'b0;
      rx_overrun                <= 1'b0;
      drop_overrun_packet       <= 1'b0;
      extended_deference_enable <= 1'b0;
      extra_defer_bits          <= 9'h000;
      defer_total_bits          <= `FDDC_STD_IFS_BITS;
    end else begin
      tx_selftest_run  <= (tx_state_q == ST_RUN) & tx_en;
      tx_selftest_mode <= diag_ctrl_q[`FDDC_TX_MODE_BIT];
      tx_selftest_addr <= tx_cnt_q;
      rx_selftest_run  <= (rx_state_q == ST_RUN) & rx_en;
      rx_selftest_mode <= diag_ctrl_q[`FDDC_RX_MODE_BIT];
      rx_selftest_addr <= rx_cnt_q;
      power_event_out  <= power_event_req
                          & ~diag_ctrl_q[`FDDC_PME_BLOCK_BIT];
      rx_overrun       <= overrun_now;
      drop_overrun_packet <= overrun_now
                             & ~diag_ctrl_q[`FDDC_RETAIN_BIT];
      extended_deference_enable <= defer_en;
      if (defer_en) begin
        extra_defer_bits <= defer_bits(defer_code);
        defer_total_bits <= `FDDC_STD_IFS_BITS
                            + {1'b0, defer_bits(defer_code)};
      end else begin
        extra_defer_bits <= 9'h000;
        defer_total_bits <= `FDDC_STD_IFS_BITS;
      end
    end
  end

endmodule // fddc_top
`default_nettype wire

// ### test/fddc_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module fddc_checker (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       power_event_req,
  input wire logic       power_event_out,
  input wire logic       rx_fifo_full,
  input wire logic       rx_data_arrive,
  input wire logic       rx_overrun,
  input wire logic       drop_overrun_packet,
  input wire logic       extended_deference_enable,
  input wire logic [8:0] extra_defer_bits,
  input wire logic [9:0] defer_total_bits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_full_arrive;
    rx_fifo_full && rx_data_arrive;
  endsequence
  a_bus_ready: assert property ($past(reset_n) |-> hreadyout)
    else $error("Slave stalled the bus");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("Error response seen");
  a_pme_cause: assert property (power_event_out |-> $past(power_event_req))
    else $error("Power event without request");
  a_overrun_seen: assert property (s_full_arrive |=> rx_overrun)
    else $error("Overrun missed");
  a_overrun_cause: assert property (rx_overrun |-> $past(rx_fifo_full && rx_data_arrive))
    else $error("Overrun without arrival on full");
  a_drop_subset: assert property (drop_overrun_packet |-> rx_overrun)
    else $error("Drop without overrun");
  a_defer_sum: assert property (defer_total_bits == extra_defer_bits + 9'h060)
    else $error("Total defer not standard plus extra");
  a_defer_off: assert property (!extended_deference_enable |-> extra_defer_bits == 9'h000)
    else $error("Extra defer while disabled");
  a_defer_grid: assert property (extended_deference_enable |-> extra_defer_bits[3:0] == 4'h0 && extra_defer_bits <= 9'h1C0)
    else $error("Extra defer off grid");
endmodule // fddc_checker
bind fddc_top fddc_checker i_chk (.clk(clk), .reset_n(reset_n),
  .hreadyout(hreadyout), .hresp(hresp), .power_event_req(power_event_req),
  .power_event_out(power_event_out), .rx_fifo_full(rx_fifo_full),
  .rx_data_arrive(rx_data_arrive), .rx_overrun(rx_overrun),
  .drop_overrun_packet(drop_overrun_packet),
  .extended_deference_enable(extended_deference_enable),
  .extra_defer_bits(extra_defer_bits), .defer_total_bits(defer_total_bits));
`default_nettype wire

// ### test/fifo_diag_and_defer_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "fddc_defs.vh"
module fifo_diag_and_defer_control_tb_top;
  localparam logic [7:0] diag_i = `FDDC_IDX_FIFO_DIAG;
  localparam logic [7:0] mac_i  = `FDDC_IDX_MAC_CTRL;
  localparam logic [7:0] ist_i  = `FDDC_IDX_INT_STATUS;
  localparam logic [7:0] imk_i  = `FDDC_IDX_INT_MASK;
  logic        clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        tx_selftest_miscompare = 1'b0, rx_selftest_miscompare = 1'b0;
  logic        power_event_req = 1'b0, rx_fifo_full = 1'b0;
  logic        rx_data_arrive = 1'b0, rx_packet_active = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, tx_selftest_run, tx_selftest_mode;
  wire         rx_selftest_run, rx_selftest_mode, power_event_out;
  wire         rx_overrun, drop_overrun_packet, extended_deference_enable;
  wire         irq;
  wire  [9:0]  tx_selftest_addr, rx_selftest_addr;
  wire  [8:0]  extra_defer_bits;
  wire  [9:0]  defer_total_bits;
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  int          ovr_cnt = 0, drop_cnt = 0, run_cnt = 0, rx_run_cnt = 0;
  logic [31:0] d;

  fddc_top i_dut (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .tx_selftest_run, .tx_selftest_mode, .tx_selftest_addr,
    .tx_selftest_miscompare, .rx_selftest_run, .rx_selftest_mode,
    .rx_selftest_addr, .rx_selftest_miscompare, .power_event_req,
    .power_event_out, .rx_fifo_full, .rx_data_arrive, .rx_packet_active,
    .rx_overrun, .drop_overrun_packet, .extended_deference_enable,
    .extra_defer_bits, .defer_total_bits, .irq);

  always #2.5 clk = ~clk;
  // ****************************************
  // Monitors and timeout
  // ****************************************
  always @(negedge clk) begin
    if (rx_overrun === 1'b1) ovr_cnt++;
    if (drop_overrun_packet === 1'b1) drop_cnt++;
    if (tx_selftest_run === 1'b1) run_cnt++;
    if (rx_selftest_run === 1'b1) rx_run_cnt++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic addr_ph(input logic [7:0] idx, input logic wr);
    hsel   <= 1'b1;
    htrans <= `FDDC_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] v);
    addr_ph(idx, 1'b1);
    hwdata <= {16'h0, v};
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] v);
    addr_ph(idx, 1'b0);
    do @(posedge clk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    rd(idx, v);
    chk(v, exp);
  endtask
  task automatic pulse_arrive;
    rx_data_arrive <= 1'b1;
    @(posedge clk);
    rx_data_arrive <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [8:0] exp_extra(input logic [3:0] c);
    return (c < 4'h3) ? {1'b0, c, 4'h0} : {c - 4'h1, 5'h00};
  endfunction
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rchk(diag_i, 32'h0);
    rchk(mac_i, 32'h0);
    wr(8'h30, 16'hFFFF);
    rchk(8'h30, 32'h0);
    $display("Test reset values ended");
    for (int c = 0; c < 16; c++) begin
      wr(mac_i, {11'h0, c[3:0], 1'b1});
      rchk(mac_i, {27'h0, c[3:0], 1'b1});
      chk({23'h0, extra_defer_bits}, {23'h0, exp_extra(c[3:0])});
      chk({22'h0, defer_total_bits}, 32'h60 + exp_extra(c[3:0]));
      chk({31'h0, extended_deference_enable}, 32'h1);
    end
    wr(mac_i, 16'hFFFF);
    rchk(mac_i, 32'h1F);
    wr(mac_i, 16'h001E);
    rchk(mac_i, 32'h1E);
    chk({23'h0, extra_defer_bits}, 32'h0);
    chk({22'h0, defer_total_bits}, 32'h60);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rchk(mac_i, 32'h0);
    chk({22'h0, defer_total_bits}, 32'h60);
    $display("Test defer control ended");
    wr(diag_i, 16'h0300);
    rx_fifo_full     <= 1'b1;
    rx_packet_active <= 1'b1;
    power_event_req  <= 1'b1;
    rchk(diag_i, 32'h8B00);
    chk({31'h0, power_event_out}, 32'h0);
    pulse_arrive();
    chk(ovr_cnt, 1);
    chk(drop_cnt, 0);
    wr(diag_i, 16'h0000);
    pulse_arrive();
    chk(drop_cnt, 1);
    chk({31'h0, power_event_out}, 32'h1);
    rx_fifo_full     <= 1'b0;
    rx_packet_active <= 1'b0;
    pulse_arrive();
    chk(ovr_cnt, 2);
    rchk(diag_i, 32'h0);
    rchk(ist_i, 32'h4);
    chk({31'h0, irq}, 32'h0);
    wr(imk_i, 16'h0007);
    rchk(imk_i, 32'h7);
    chk({31'h0, irq}, 32'h1);
    wr(ist_i, 16'h0004);
    rchk(ist_i, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("Test status and overrun ended");
    tx_selftest_miscompare <= 1'b1;
    wr(diag_i, 16'h0031);
    rchk(diag_i, 32'h31);
    chk({30'h0, tx_selftest_mode, rx_selftest_mode}, 32'h1);
    d = 32'h0;
    for (int i = 0; i < 400 && (d[3] !== 1'b1 || d[7] !== 1'b1); i++)
      rd(diag_i, d);
    chk(d, 32'hBD);
    chk(run_cnt, 512);
    chk(rx_run_cnt, 512);
    chk({22'h0, tx_selftest_addr}, {22'h0, `FDDC_BIST_LAST});
    chk({22'h0, rx_selftest_addr}, {22'h0, `FDDC_BIST_LAST});
    rchk(ist_i, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(ist_i, 16'h0003);
    wr(diag_i, 16'h0030);
    rchk(diag_i, 32'hBC);
    wr(diag_i, 16'h0033);
    rchk(diag_i, 32'hB3);
    chk({30'h0, tx_selftest_mode, rx_selftest_mode}, 32'h3);
    wr(diag_i, 16'h0000);
    rchk(diag_i, 32'h80);
    $display("Test self-test ended");
    give_verdict();
  end
endmodule // fifo_diag_and_defer_control_tb_top
`default_nettype wire
